// >>> ppl_pkg.sv
// package: constants for the phy power, reset and link control block
package ppl_pkg;
    localparam int CLK_HZ = 40_000_000;
    localparam int SPEED_SLOW_US = 16;
    localparam int SPEED_SLOW_CYC = (SPEED_SLOW_US * (CLK_HZ / 1_000_000));
    localparam int LINK_WAIT_US = 330;
    localparam int LINK_WAIT_CYC = (LINK_WAIT_US * (CLK_HZ / 1_000_000));
    localparam int SRST_MAX_MS = 500;
    localparam int SRST_CYC = 16;
    localparam int SRST_MAX_CYC = (SRST_MAX_MS * (CLK_HZ / 1_000));
    localparam int CRS_WIN = 10;
    localparam int ONES_RUN = 10;
    localparam logic [4:0] SYM_J = 5'h18;
    localparam logic [4:0] SYM_K = 5'h11;
    localparam logic [4:0] SYM_T = 5'h0D;
    localparam logic [4:0] SYM_R = 5'h07;
    localparam logic [4:0] SYM_IDLE = 5'h1F;
    localparam logic [1:0] CTRL_RST = 2'h0;
    localparam logic [7:0] CFG_RST = 8'h00;
    localparam logic [7:0] PRES_RST = 8'h00;
    localparam logic [1:0] RMII_IDLE = 2'h0;
    typedef enum logic [2:0] {
        PPL_LNK_DOWN = 3'b001,
        PPL_LNK_WAIT = 3'b010,
        PPL_LNK_READY = 3'b100
    } ppl_link_e;
    typedef enum logic [3:0] {
        PPL_CRS_IDLE = 4'b0001,
        PPL_CRS_PRE = 4'b0010,
        PPL_CRS_STRM = 4'b0100,
        PPL_CRS_END = 4'b1000
    } ppl_crs_e;
endpackage

// >>> ppl_top.sv
// module: operating-mode, carrier, link and loopback control of the phy
//
// Notes on behaviour
// - power-down bit set keeps all but management powered down until cleared.
// - clearing power-down powers up and internally resets the transceiver.
// - energy-detect enable with no energy powers down all but detect logic.
// - energy-detect sleep transmits nothing; arriving energy raises flag, wakes.
// - wake restores prior state; unmasked energy interrupt drives low output.
// - isolate ignores mac transmit inputs; management still works; zero at reset.
// - both resets clear registers; preserved bits survive soft reset.
// - rmii runs at 2.5 MHz first 16us after reset, then 25 MHz with aneg.
// - soft reset bit starts reset, self-clears, done within 0.5 s.
// - repeater or full duplex: carrier from receive only, else either.
// - carrier on two non-adjacent zeros inside any ten-bit window.
// - carrier drops on ten ones before a j/k start pair.
// - after start pair carrier holds until t or first idle, with exceptions.
// - 100 and 10 link results merged into one status and led.
// - data valid leads to ready, aneg done then link up; no aneg direct.
// - wait at least 330 us after data valid before ready.
// - data valid loss drops link immediately into down state.
// - in 10 Mbps mode link comes from the 10 Mbps receiver.
// - near loopback returns tx data to rx outputs; line drivers stay off.
// - far loopback resends line data; mac side isolated.
`timescale 1ns/1ps
module ppl_top #(
    parameter int LINK_WAIT = ppl_pkg::LINK_WAIT_CYC,
    parameter int SPEED_SLOW = ppl_pkg::SPEED_SLOW_CYC
) (
    input wire logic i_core_clk,
    input wire logic i_reset,
    input wire logic i_hw_reset_n,
    input wire logic i_power_down,
    input wire logic i_soft_reset_set,
    input wire logic i_isolate,
    input wire logic i_near_loop,
    input wire logic i_far_loop_enable,
    input wire logic i_energy_detect_pd_enable,
    input wire logic i_energy_irq_mask,
    input wire logic i_energy_irq_clear,
    input wire logic i_line_energy,
    input wire logic i_aneg_enable,
    input wire logic i_aneg_done,
    input wire logic i_full_duplex,
    input wire logic i_repeater,
    input wire logic i_speed_10,
    input wire logic i_link_10,
    input wire logic i_data_valid,
    input wire logic [7:0] i_cfg_wr_data,
    input wire logic i_cfg_wr,
    input wire logic [7:0] i_pres_wr_data,
    input wire logic i_pres_wr,
    input wire logic [1:0] i_txd,
    input wire logic i_tx_en,
    input wire logic i_tx_er,
    input wire logic [4:0] i_rx_sym,
    input wire logic i_rx_sym_valid,
    input wire logic [1:0] i_line_rxd,
    input wire logic i_line_rx_dv,
    output logic o_soft_reset_busy,
    output logic o_core_powered,
    output logic o_xcvr_reset,
    output logic o_energy_present_flag,
    output logic o_irq_out_n,
    output logic o_rmii_fast,
    output logic o_carrier,
    output logic o_link_status,
    output logic o_link_indicator_led,
    output logic o_tx_active,
    output logic [1:0] o_tx_line_data,
    output logic o_tx_line_en,
    output logic o_line_drv_on,
    output logic [1:0] o_rxd,
    output logic o_crs_dv,
    output logic [7:0] o_cfg,
    output logic [7:0] o_pres
);
    import ppl_pkg::*;

    // ------------------------------------------------------------
    // resets and power control
    // ------------------------------------------------------------
    logic rst_any;
    logic srst_q, srst_d;
    logic [4:0] srst_cnt_q;
    logic pd_q;
    logic edpd_sleep;
    logic energy_q;
    logic irq_q;
    logic powered;
    logic xrst_q;
    logic [7:0] cfg_q;
    logic [7:0] pres_q;
    logic soft_hit;
    wire hard_rst = i_reset | ~i_hw_reset_n;
    assign soft_hit = srst_q && (srst_cnt_q == 5'(SRST_CYC - 1));
    assign rst_any = hard_rst | srst_q;
    assign srst_d = srst_q ? ~soft_hit : i_soft_reset_set;

    always_ff @(posedge i_core_clk) begin
        if (hard_rst) begin
            srst_q <= 1'b0;
            srst_cnt_q <= 5'h00;
        end else begin
            srst_q <= srst_d;
            srst_cnt_q <= srst_q ? srst_cnt_q + 5'h01 : 5'h00;
        end
    end

    // registers: cfg cleared by either reset, pres only by hardware
    always_ff @(posedge i_core_clk) begin
        if (rst_any) begin
            cfg_q <= CFG_RST;
        end else if (i_cfg_wr) begin
            cfg_q <= i_cfg_wr_data;
        end
    end
    always_ff @(posedge i_core_clk) begin
        if (hard_rst) begin
            pres_q <= PRES_RST;
        end else if (i_pres_wr) begin
            pres_q <= i_pres_wr_data;
        end
    end

    // power-down never touches registers; falling edge pulses internal reset
    always_ff @(posedge i_core_clk) begin
        if (rst_any) begin
            pd_q <= 1'b0;
            xrst_q <= 1'b0;
        end else begin
            pd_q <= i_power_down;
            xrst_q <= pd_q & ~i_power_down;
        end
    end

    assign edpd_sleep = i_energy_detect_pd_enable & ~i_line_energy;
    assign powered = ~i_power_down & ~edpd_sleep;

    // energy flag and interrupt; set wins over clear
    always_ff @(posedge i_core_clk) begin
        if (rst_any) begin
            energy_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            energy_q <= i_line_energy;
            if (i_energy_detect_pd_enable && i_line_energy && !energy_q) begin
                irq_q <= 1'b1;
            end else if (i_energy_irq_clear) begin
                irq_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // rmii speed after reset
    // ------------------------------------------------------------
    logic [15:0] slow_cnt_q;
    logic slow_done;
    assign slow_done = (slow_cnt_q == 16'(SPEED_SLOW));
    always_ff @(posedge i_core_clk) begin
        if (rst_any) begin
            slow_cnt_q <= 16'h0000;
        end else if (!slow_done) begin
            slow_cnt_q <= slow_cnt_q + 16'h0001;
        end
    end

    // ------------------------------------------------------------
    // carrier sense from 5-bit symbols
    // ------------------------------------------------------------
    ppl_crs_e crs_q;
    ppl_crs_e crs_d;
    logic [CRS_WIN-1:0] win_q;
    logic [CRS_WIN-1:0] win_d;
    logic [4:0] prev_q;
    logic zeros2;
    logic ones10;
    logic rx_act;
    logic ssd_seen;
    logic esd_seen;
    logic idle_pair;
    assign win_d = {win_q[4:0], i_rx_sym};
    assign ssd_seen = (prev_q == SYM_J) && (i_rx_sym == SYM_K);
    assign esd_seen = (prev_q == SYM_T) && (i_rx_sym == SYM_R);
    assign idle_pair = (prev_q == SYM_IDLE) && (i_rx_sym == SYM_IDLE);

    // two zeros not next to each other anywhere in the window
    function automatic logic two_sep_zeros(input logic [CRS_WIN-1:0] w);
        logic hit;
        hit = 1'b0;
        for (int a = 0; a < CRS_WIN; a++) begin
            for (int b = a + 2; b < CRS_WIN; b++) begin
                if (!w[a] && !w[b]) begin
                    hit = 1'b1;
                end
            end
        end
        return hit;
    endfunction
    assign zeros2 = two_sep_zeros(win_d);
    assign ones10 = &win_d;

    always_comb begin
        crs_d = crs_q;
        unique case (crs_q)
            PPL_CRS_IDLE: begin
                if (zeros2) begin
                    crs_d = PPL_CRS_PRE;
                end
            end
            PPL_CRS_PRE: begin
                if (ssd_seen) begin
                    crs_d = PPL_CRS_STRM;
                end else if (ones10) begin
                    crs_d = PPL_CRS_IDLE;
                end
            end
            PPL_CRS_STRM: begin
                if (i_rx_sym == SYM_T || i_rx_sym == SYM_IDLE) begin
                    crs_d = PPL_CRS_END;
                end
            end
            PPL_CRS_END: begin
                if (esd_seen || idle_pair) begin
                    crs_d = PPL_CRS_IDLE;
                end else if (i_rx_sym != SYM_IDLE) begin
                    crs_d = PPL_CRS_STRM;
                end
            end
            default: crs_d = PPL_CRS_IDLE;
        endcase
    end

    always_ff @(posedge i_core_clk) begin
        if (rst_any || !powered) begin
            crs_q <= PPL_CRS_IDLE;
            win_q <= '1;
            prev_q <= SYM_IDLE;
        end else if (i_rx_sym_valid) begin
            crs_q <= crs_d;
            win_q <= win_d;
            prev_q <= i_rx_sym;
        end
    end
    // negated right after t or first idle
    assign rx_act = (crs_q == PPL_CRS_PRE) || (crs_q == PPL_CRS_STRM);

    // ------------------------------------------------------------
    // 100 Mbps link monitor
    // ------------------------------------------------------------
    ppl_link_e lnk_q;
    logic link_up_q;
    logic [15:0] lwait_q;
    always_ff @(posedge i_core_clk) begin
        if (rst_any || !powered || !i_data_valid) begin
            lnk_q <= PPL_LNK_DOWN;
            link_up_q <= 1'b0;
            lwait_q <= 16'h0000;
        end else begin
            unique case (lnk_q)
                PPL_LNK_DOWN: begin
                    lnk_q <= PPL_LNK_WAIT;
                    lwait_q <= 16'h0001;
                end
                PPL_LNK_WAIT: begin
                    if (lwait_q >= 16'(LINK_WAIT)) begin
                        lnk_q <= PPL_LNK_READY;
                    end else begin
                        lwait_q <= lwait_q + 16'h0001;
                    end
                end
                PPL_LNK_READY: begin
                    if (!i_aneg_enable || i_aneg_done) begin
                        link_up_q <= 1'b1;
                    end
                end
                default: lnk_q <= PPL_LNK_DOWN;
            endcase
        end
    end

    // ------------------------------------------------------------
    // data paths and outputs
    // ------------------------------------------------------------
    logic mac_cut;
    logic tx_ok;
    logic [1:0] rxd_d;
    logic crs_dv_d;
    logic carrier_d;
    logic link_d;
    logic link_100;
    assign mac_cut = i_isolate | i_far_loop_enable;
    assign tx_ok = powered & ~mac_cut & i_tx_en & ~i_tx_er;
    assign carrier_d = (i_repeater | i_full_duplex) ? rx_act
                     : (rx_act | tx_ok);
    assign link_100 = link_up_q & i_data_valid;
    assign link_d = i_speed_10 ? i_link_10 : link_100;
    assign rxd_d = mac_cut ? RMII_IDLE
                 : i_near_loop ? (tx_ok ? i_txd : RMII_IDLE)
                 : i_line_rxd;
    assign crs_dv_d = mac_cut ? 1'b0
                    : i_near_loop ? tx_ok
                    : (carrier_d | i_line_rx_dv);

    always_ff @(posedge i_core_clk) begin
        if (rst_any) begin
            o_tx_line_data <= RMII_IDLE;
            o_tx_line_en <= 1'b0;
            o_rxd <= RMII_IDLE;
            o_crs_dv <= 1'b0;
            o_carrier <= 1'b0;
            o_link_status <= 1'b0;
        end else begin
            if (i_far_loop_enable && powered) begin
                o_tx_line_data <= i_line_rxd;
                o_tx_line_en <= i_line_rx_dv;
            end else begin
                o_tx_line_data <= (tx_ok && !i_near_loop) ? i_txd : RMII_IDLE;
                o_tx_line_en <= tx_ok & ~i_near_loop;
            end
            o_rxd <= powered ? rxd_d : RMII_IDLE;
            o_crs_dv <= powered & crs_dv_d;
            o_carrier <= carrier_d;
            o_link_status <= link_d;
        end
    end

    // ------------------------------------------------------------
    // status and drive outputs
    // ------------------------------------------------------------
    assign o_soft_reset_busy = srst_q;
    assign o_core_powered = powered;
    assign o_xcvr_reset = xrst_q | rst_any;
    assign o_energy_present_flag = energy_q;
    assign o_irq_out_n = ~(irq_q & i_energy_irq_mask);
    assign o_rmii_fast = slow_done & i_aneg_enable;
    assign o_link_indicator_led = o_link_status;
    assign o_tx_active = tx_ok;
    assign o_line_drv_on = powered & ~i_near_loop;
    assign o_cfg = cfg_q;
    assign o_pres = pres_q;
endmodule

// >>> ppl_top_chk.sv
// checker: port assertions of the phy mode control block
`timescale 1ns/1ps
module ppl_top_chk #(
    parameter int LINK_WAIT = 20,
    parameter int SPEED_SLOW = 10
) (
    input wire logic i_core_clk,
    input wire logic i_reset,
    input wire logic i_hw_reset_n,
    input wire logic i_power_down,
    input wire logic i_isolate,
    input wire logic i_near_loop,
    input wire logic i_far_loop_enable,
    input wire logic i_aneg_enable,
    input wire logic i_data_valid,
    input wire logic i_speed_10,
    input wire logic o_soft_reset_busy,
    input wire logic o_core_powered,
    input wire logic o_xcvr_reset,
    input wire logic o_rmii_fast,
    input wire logic o_link_status,
    input wire logic o_link_indicator_led,
    input wire logic o_line_drv_on,
    input wire logic o_tx_line_en,
    input wire logic [1:0] o_rxd,
    input wire logic o_crs_dv,
    input wire logic [7:0] o_cfg
);
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_reset || !i_hw_reset_n);
    property p_pd; i_power_down |-> !o_core_powered; endproperty
    a_pd: assert property (p_pd) else $error("powered in power-down");
    property p_pd_clr; $fell(i_power_down) |-> ##[0:2] o_xcvr_reset; endproperty
    a_pd_clr: assert property (p_pd_clr) else $error("no reset after wake");
    property p_iso; i_isolate || i_far_loop_enable |=> o_rxd == 2'h0 && !o_crs_dv; endproperty
    a_iso: assert property (p_iso) else $error("receive active while isolated");
    property p_tx_iso; i_isolate && !i_far_loop_enable |=> !o_tx_line_en; endproperty
    a_tx_iso: assert property (p_tx_iso) else $error("transmit while isolated");
    property p_near; i_near_loop |-> !o_line_drv_on; endproperty
    a_near: assert property (p_near) else $error("line driver on in loopback");
    property p_drop; !i_data_valid && !i_speed_10 |=> !o_link_status; endproperty
    a_drop: assert property (p_drop) else $error("link kept without valid");
    property p_led; o_link_indicator_led == o_link_status; endproperty
    a_led: assert property (p_led) else $error("led differs from link");
    property p_noaneg; !i_aneg_enable |-> !o_rmii_fast; endproperty
    a_noaneg: assert property (p_noaneg) else $error("fast without aneg");
    property p_slow; $fell(i_reset) |-> !o_rmii_fast [*8]; endproperty
    a_slow: assert property (p_slow) else $error("fast too soon");
    property p_srst; $rose(o_soft_reset_busy) |=> o_cfg == 8'h00; endproperty
    a_srst: assert property (p_srst) else $error("cfg kept on soft reset");
    property p_srst_len;
        $rose(o_soft_reset_busy) |-> o_soft_reset_busy [*8] ##1 o_soft_reset_busy [*8]
            ##1 !o_soft_reset_busy;
    endproperty
    a_srst_len: assert property (p_srst_len) else $error("soft reset length");
    c_srst: cover property ($rose(o_soft_reset_busy));
    c_link: cover property ($rose(o_link_status));
    c_fast: cover property ($rose(o_rmii_fast));
endmodule
bind ppl_top ppl_top_chk #(.LINK_WAIT(LINK_WAIT), .SPEED_SLOW(SPEED_SLOW)) u_chk (
    .i_core_clk(i_core_clk), .i_reset(i_reset), .i_hw_reset_n(i_hw_reset_n),
    .i_power_down(i_power_down), .i_isolate(i_isolate), .i_near_loop(i_near_loop),
    .i_far_loop_enable(i_far_loop_enable), .i_aneg_enable(i_aneg_enable),
    .i_data_valid(i_data_valid), .i_speed_10(i_speed_10),
    .o_soft_reset_busy(o_soft_reset_busy), .o_core_powered(o_core_powered),
    .o_xcvr_reset(o_xcvr_reset), .o_rmii_fast(o_rmii_fast), .o_link_status(o_link_status),
    .o_link_indicator_led(o_link_indicator_led), .o_line_drv_on(o_line_drv_on),
    .o_tx_line_en(o_tx_line_en), .o_rxd(o_rxd), .o_crs_dv(o_crs_dv), .o_cfg(o_cfg)
);

// >>> ppl_link_partner.sv
// partner: line side model sending symbols and receive data
`timescale 1ns/1ps
module ppl_link_partner (
    input wire logic i_core_clk,
    output logic [4:0] o_sym,
    output logic o_sym_valid,
    output logic [1:0] o_rxd,
    output logic o_rx_dv
);
    initial begin
        {o_sym, o_sym_valid, o_rxd, o_rx_dv} = '0;
    end
    // released data shows the inverse of the last value
    task automatic send(input logic [4:0] s);
        o_sym = s;
        o_sym_valid = 1'b1;
        @(negedge i_core_clk);
    endtask
    task automatic stop;
        o_sym_valid = 1'b0;
        o_sym = ~o_sym;
    endtask
    task automatic line(input logic dv, input logic [1:0] d);
        o_rx_dv = dv;
        o_rxd = dv ? d : ~d;
    endtask
endmodule

// >>> ppl_top_tb.sv
// testbench: self-checking sequences for the phy mode control block
`timescale 1ns/1ps
module ppl_top_tb;
    import ppl_pkg::*;
    localparam int LW = 20;
    localparam int SL = 10;
    logic clk, rst, hw_n, pd, srst, iso, near, far, edpd, imask, iclr, energy, aneg, adone;
    logic fdx, rep, sp10, lnk10, dv, cfg_wr, pres_wr, tx_en, tx_er, sym_v, lrx_dv;
    logic busy, pwr, xrst, eflag, irq_n, fast, crs, link, led, txa, tx_le, drv, crs_dv;
    logic [7:0] cfg_d, pres_d, cfg, pres;
    logic [1:0] txd, lrxd, tx_ld, rxd;
    logic [4:0] sym;
    logic [4:0] seq [14] = '{SYM_J, SYM_K, 5'h0E, SYM_T, SYM_R, SYM_IDLE, 5'h1E, 5'h1E,
        SYM_IDLE, SYM_IDLE, SYM_J, SYM_K, SYM_T, 5'h0E};
    int miscompares = 0;
    int compares = 0;
    int n;
    ppl_top #(.LINK_WAIT(LW), .SPEED_SLOW(SL)) uut (
        .i_core_clk(clk), .i_reset(rst), .i_hw_reset_n(hw_n), .i_power_down(pd),
        .i_soft_reset_set(srst), .i_isolate(iso), .i_near_loop(near), .i_far_loop_enable(far),
        .i_energy_detect_pd_enable(edpd), .i_energy_irq_mask(imask), .i_energy_irq_clear(iclr),
        .i_line_energy(energy), .i_aneg_enable(aneg), .i_aneg_done(adone),
        .i_full_duplex(fdx), .i_repeater(rep), .i_speed_10(sp10), .i_link_10(lnk10),
        .i_data_valid(dv), .i_cfg_wr_data(cfg_d), .i_cfg_wr(cfg_wr), .i_pres_wr_data(pres_d),
        .i_pres_wr(pres_wr), .i_txd(txd), .i_tx_en(tx_en), .i_tx_er(tx_er), .i_rx_sym(sym),
        .i_rx_sym_valid(sym_v), .i_line_rxd(lrxd), .i_line_rx_dv(lrx_dv),
        .o_soft_reset_busy(busy), .o_core_powered(pwr), .o_xcvr_reset(xrst),
        .o_energy_present_flag(eflag), .o_irq_out_n(irq_n), .o_rmii_fast(fast),
        .o_carrier(crs), .o_link_status(link), .o_link_indicator_led(led), .o_tx_active(txa),
        .o_tx_line_data(tx_ld), .o_tx_line_en(tx_le), .o_line_drv_on(drv), .o_rxd(rxd),
        .o_crs_dv(crs_dv), .o_cfg(cfg), .o_pres(pres)
    );
    ppl_link_partner lp (
        .i_core_clk(clk), .o_sym(sym), .o_sym_valid(sym_v), .o_rxd(lrxd), .o_rx_dv(lrx_dv)
    );
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic chkb(input logic got, input logic exp);
        chk({7'h00, got}, {7'h00, exp});
    endtask
    task automatic cyc(input int k);
        repeat (k) @(negedge clk);
    endtask
    task automatic play(input int a, input int b);
        for (int i = a; i <= b; i++) begin
            lp.send(seq[i]);
        end
        lp.stop();
        cyc(3);
    endtask
    task automatic final_report;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        #100000;
        miscompares++;
        final_report();
    end
    initial begin
        {hw_n, pd, srst, iso, near, far, edpd, imask, iclr, energy, adone, fdx, rep} = '0;
        {sp10, lnk10, dv, cfg_wr, pres_wr, tx_en, tx_er, cfg_d, pres_d, txd} = '0;
        rst = 1'b1;
        aneg = 1'b1;
        cyc(10);
        rst = 1'b0;
        hw_n = 1'b1;
        cyc(3);
        chkb(fast, 1'b0);
        chkb(irq_n, 1'b1);
        cyc(SL);
        chkb(fast, 1'b1);
        {cfg_wr, pres_wr, cfg_d, pres_d} = {2'b11, 8'hA5, 8'h5A};
        cyc(1);
        {cfg_wr, pres_wr, srst} = 3'b001;
        cyc(1);
        srst = 1'b0;
        chkb(busy, 1'b1);
        cyc(1);
        chk(cfg, 8'h00);
        chk(pres, 8'h5A);
        cyc(16);
        chkb(busy, 1'b0);
        {hw_n, cfg_wr, cfg_d} = {2'b01, 8'h3C};
        cyc(2);
        {hw_n, cfg_wr} = 2'b11;
        cyc(1);
        {cfg_wr, pd} = 2'b01;
        cyc(2);
        chk(pres, 8'h00);
        chkb(pwr, 1'b0);
        chkb(xrst, 1'b0);
        pd = 1'b0;
        cyc(1);
        chkb(xrst, 1'b1);
        cyc(2);
        chkb(xrst, 1'b0);
        chkb(pwr, 1'b1);
        chk(cfg, 8'h3C);
        {edpd, imask, tx_en} = 3'b111;
        cyc(2);
        chkb(pwr, 1'b0);
        chkb(tx_le, 1'b0);
        energy = 1'b1;
        cyc(3);
        chkb(eflag, 1'b1);
        chkb(irq_n, 1'b0);
        chkb(tx_le, 1'b1);
        iclr = 1'b1;
        cyc(1);
        {iclr, edpd, iso} = 3'b001;
        cyc(2);
        chkb(irq_n, 1'b1);
        chkb(tx_le, 1'b0);
        {iso, near} = 2'b01;
        txd = 2'h3;
        cyc(2);
        chkb(drv, 1'b0);
        chk({6'h00, rxd}, 8'h03);
        chkb(tx_le, 1'b0);
        chkb(txa, 1'b1);
        {near, far} = 2'b01;
        lp.line(1'b1, 2'h2);
        cyc(3);
        chkb(tx_le, 1'b1);
        chkb(crs_dv, 1'b0);
        chk({6'h00, tx_ld}, 8'h02);
        chk({6'h00, rxd}, 8'h00);
        chkb(txa, 1'b0);
        far = 1'b0;
        lp.line(1'b0, 2'h0);
        for (int i = 0; i < 4; i++) begin
            {fdx, rep} = 2'(i);
            cyc(3);
            chkb(crs, i == 0);
        end
        {fdx, rep, tx_en, aneg, dv} = 5'b00001;
        n = 0;
        while (link !== 1'b1 && n < 100) begin
            cyc(1);
            n++;
        end
        chkb(n >= LW && n <= LW + 3, 1'b1);
        chkb(led, 1'b1);
        {dv, sp10, lnk10} = 3'b011;
        cyc(2);
        chkb(link, 1'b1);
        {sp10, lnk10} = 2'b10;
        cyc(2);
        chkb(link, 1'b0);
        {sp10, aneg, dv} = 3'b011;
        cyc(LW + 8);
        chkb(link, 1'b0);
        adone = 1'b1;
        cyc(3);
        chkb(link, 1'b1);
        play(0, 2);
        chkb(crs, 1'b1);
        play(3, 5);
        chkb(crs, 1'b0);
        play(6, 7);
        chkb(crs, 1'b1);
        play(8, 9);
        chkb(crs, 1'b0);
        play(10, 13);
        chkb(crs, 1'b1);
        dv = 1'b0;
        cyc(1);
        chkb(link, 1'b0);
        final_report();
    end
endmodule
